// *** src/nand_otp_seq.sv ***
// Command sequencer for the one-time area and multi-LUN operation
//
// Overview of operation
// - 80h, address 00h-00h-01h-00h-00h, 10h is taken as the protect request.
// - After a passing protect, one-time pages are never programmed again.
// - Protect holds ready/busy low for program time; ready bit follows it.
// - Protect on an already protected area: busy one-time time, status 60h.
// - On ready the host reads pass/fail; protection counts only after pass.
// - One-time read is 00h, two column and three page cycles, then 30h.
// - One-time read clears ready and array-ready of the LUN for read time.
// - After polling, 00h switches to data output from the given column.
// - One-time page data is returned whether or not the area is protected.
// - Shared ready/busy stays low while any LUN is busy.
// - Status bit 6 shows ready for more data, bit 5 all work done.
// - Factory bad blocks read 00h at byte 4096 of their first page.
// - Feature 90h with 01h,00h,00h,00h enters one-time mode; all zero leaves.
`timescale 1ns/100ps
`include "nand_otp_consts.svh"
module nand_otp_seq
  import nand_otp_pkg::*;
#(
  parameter int unsigned ARRAY_PROGRAM_CYC = `ARRAY_PROGRAM_TIME_NS / `CLK_PERIOD_NS,
  parameter int unsigned OTP_BUSY_CYC      = `OTP_BUSY_TIME_NS / `CLK_PERIOD_NS,
  parameter int unsigned PAGE_READ_CYC     = `PAGE_READ_TIME_NS / `CLK_PERIOD_NS,
  parameter logic [15:0] FACTORY_BAD_BLOCK = 16'hFFFF,
  parameter int          LUN_BIT           = 0
) (
  input  wire logic i_sys_clk,
  input  wire logic i_nrst,
  input  host_in_t  i_host,
  output host_out_t o_host,
  output logic      o_otp_mode,
  output logic      o_otp_protected
);

  localparam int MEM_AW = 5 + COL_W;

  seq_state_t         st;
  seq_state_t         next_st;
  logic [LUN_N-1:0]   lun_busy;
  logic [LUN_N-1:0]   tmr_start;
  logic [CYC_W-1:0]   tmr_cyc;
  logic               mem_we;
  logic [MEM_AW-1:0]  mem_waddr;
  logic [MEM_AW-1:0]  mem_raddr;
  logic [7:0]         mem_rdata;
  logic               cur_lun;
  logic               protect_go;
  logic               otp_read_go;
  logic               feat_done;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [7:0] status_byte(input logic busy, input logic refused);
    // Refused and ready gives exactly 60h
    status_byte = {~refused, ~busy, ~busy, 5'h00};
  endfunction

  function automatic logic otp_page_ok(input logic [7:0] page);
    otp_page_ok = (page >= `OTP_PAGE_FIRST) && (page <= `OTP_PAGE_LAST);
  endfunction

  // ****************************************
  // Submodules
  // ****************************************
  for (genvar g = 0; g < LUN_N; g++)
  begin : g_lun
    lun_timer u_tmr (
      .i_sys_clk (i_sys_clk),
      .i_nrst    (i_nrst),
      .i_start   (tmr_start[g]),
      .i_cycles  (tmr_cyc),
      .o_busy    (lun_busy[g])
    );
  end

  otp_page_mem #(.AW(MEM_AW)) u_mem (
    .i_sys_clk (i_sys_clk),
    .i_we      (mem_we),
    .i_waddr   (mem_waddr),
    .i_wdata   (i_host.io),
    .i_raddr   (mem_raddr),
    .o_rdata   (mem_rdata)
  );

  assign cur_lun   = st.addr[4][LUN_BIT];
  assign mem_waddr = {st.addr[2][4:0], st.col};
  assign mem_raddr = {st.rd_page, st.col};

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb
  begin
    next_st     = st;
    tmr_start   = '0;
    tmr_cyc     = '0;
    mem_we      = 1'b0;
    protect_go  = 1'b0;
    otp_read_go = 1'b0;
    feat_done   = 1'b0;
    next_st.busy_q = lun_busy;

    // protection commits when the pass completes
    for (int i = 0; i < LUN_N; i++)
    begin
      if (st.pend_prot[i] && st.busy_q[i] && !lun_busy[i])
      begin
        next_st.prot = 1'b1;
        next_st.pend_prot[i] = 1'b0;
      end
    end

    if (i_host.cmd_we)
    begin
      case (i_host.io)
        `CMD_READ_MODE:
        begin
          // leave status output, next reads give data
          next_st.out_status = 1'b0;
          next_st.op   = OP_READ;
          next_st.acnt = '0;
        end
        `CMD_READ_GO:
        begin
          if (st.op == OP_READ && st.acnt == 3'd5)
          begin
            // page cycles select the one-time page
            // LUN busy for page read time
            // not gated by the protected flag
            tmr_start[cur_lun] = 1'b1;
            tmr_cyc = CYC_W'(PAGE_READ_CYC);
            otp_read_go = st.otp_mode;
            next_st.sel_lun = cur_lun;
            next_st.rd_page = st.addr[2][4:0];
            next_st.rd_otp  = st.otp_mode && otp_page_ok(st.addr[2]);
            // factory mark at first spare byte of first page
            next_st.rd_bad  = !st.otp_mode && (st.addr[2][6:0] == 7'h00)
                              && ({4'h0, st.addr[4][3:0], st.addr[3], st.addr[2][7]}
                                  == FACTORY_BAD_BLOCK);
            next_st.col = {st.addr[1][4:0], st.addr[0]};
            next_st.refused[cur_lun] = 1'b0;
          end
          next_st.op = OP_NONE;
        end
        `CMD_PROG:
        begin
          next_st.op   = OP_PROG;
          next_st.acnt = '0;
        end
        `CMD_PROG_GO:
        begin
          if (st.op == OP_PROG && st.acnt == 3'd5)
          begin
            tmr_start[cur_lun] = 1'b1;
            next_st.sel_lun = cur_lun;
            next_st.refused[cur_lun] = 1'b0;
            tmr_cyc = CYC_W'(ARRAY_PROGRAM_CYC);
            if (st.otp_mode && st.addr == `PROTECT_ADDR)
            begin
              protect_go = 1'b1;
              if (st.prot)
              begin
                tmr_cyc = CYC_W'(OTP_BUSY_CYC);
                next_st.refused[cur_lun] = 1'b1;
              end
              else
                next_st.pend_prot[cur_lun] = 1'b1;
            end
            else if (st.otp_mode && (st.prot || !otp_page_ok(st.addr[2])))
            begin
              tmr_cyc = CYC_W'(OTP_BUSY_CYC);
              next_st.refused[cur_lun] = 1'b1;
            end
          end
          next_st.op = OP_NONE;
        end
        `CMD_STATUS:
          next_st.out_status = 1'b1;
        `CMD_STATUS_LUN:
        begin
          // Not honoured in one-time mode
          if (!st.otp_mode)
          begin
            next_st.op   = OP_SEL;
            next_st.acnt = '0;
          end
        end
        `CMD_COL_CHG:
        begin
          next_st.op   = OP_COL;
          next_st.acnt = '0;
        end
        `CMD_COL_GO:
        begin
          if (st.op == OP_COL && st.acnt == 3'd2)
          begin
            next_st.col = {st.addr[1][4:0], st.addr[0]};
            next_st.out_status = 1'b0;
          end
          next_st.op = OP_NONE;
        end
        `CMD_SET_FEAT:
        begin
          next_st.op   = OP_FEAT;
          next_st.acnt = '0;
          next_st.pcnt = '0;
        end
        `CMD_RESET, `CMD_SYNC_RESET:
        begin
          next_st.otp_mode   = 1'b0;
          next_st.out_status = 1'b0;
          next_st.op         = OP_NONE;
          next_st.refused    = '0;
        end
        default:
          next_st.op = OP_NONE;
      endcase
    end
    else if (i_host.addr_we)
    begin
      if (st.op == OP_FEAT)
      begin
        next_st.feat_addr = i_host.io;
        next_st.acnt = 3'd1;
      end
      else if (st.acnt < 3'd5)
      begin
        next_st.addr[st.acnt] = i_host.io;
        next_st.acnt = st.acnt + 3'd1;
        // Status select carries only the three row cycles
        if (st.op == OP_SEL && st.acnt == 3'd2)
        begin
          next_st.sel_lun = i_host.io[LUN_BIT];
          next_st.out_status = 1'b1;
          next_st.op = OP_NONE;
        end
        if (st.op == OP_SEL)
          next_st.addr[st.acnt + 3'd2] = i_host.io;
      end
      if (st.op == OP_PROG && st.acnt == 3'd1)
        next_st.col = {i_host.io[4:0], st.addr[0]};
      if (st.op == OP_PROG && st.acnt == 3'd0)
        next_st.col = {5'h00, i_host.io};
    end
    else if (i_host.data_we)
    begin
      if (st.op == OP_FEAT && st.acnt == 3'd1 && st.pcnt < 3'd4)
      begin
        next_st.pcnt = st.pcnt + 3'd1;
        if (st.pcnt == 3'd0)
        begin
          next_st.feat_p1   = i_host.io;
          next_st.feat_zero = 1'b1;
        end
        else if (i_host.io != 8'h00)
          next_st.feat_zero = 1'b0;
        if (st.pcnt == 3'd3)
        begin
          feat_done = 1'b1;
          next_st.op = OP_NONE;
          if (st.feat_addr == `FEAT_OTP_ADDR && next_st.feat_zero)
          begin
            if (st.feat_p1 == `OTP_ENTER)
              next_st.otp_mode = 1'b1;
            else if (st.feat_p1 == 8'h00)
              next_st.otp_mode = 1'b0;
          end
        end
      end
      else if (st.op == OP_PROG && st.acnt == 3'd5)
      begin
        // no writes into a protected area
        mem_we = st.otp_mode && !st.prot && otp_page_ok(st.addr[2]);
        next_st.col = st.col + COL_W'(1);
      end
    end

    // Read pipe: stage then output, two cycles for every byte
    next_st.rd_stage = i_host.data_re;
    next_st.hout.dout_valid = st.rd_stage;
    if (st.rd_stage)
      next_st.hout.dout = st.stage_mem ? mem_rdata : st.stage_byte;
    if (i_host.data_re)
    begin
      next_st.stage_mem = !st.out_status && st.rd_otp;
      // ready and array-ready bits per selected LUN
      if (st.out_status)
        next_st.stage_byte = status_byte(lun_busy[st.sel_lun], st.refused[st.sel_lun]);
      else if (st.rd_bad && st.col == `BAD_BLOCK_BYTE)
        next_st.stage_byte = `BAD_BLOCK_MARK;
      else
        next_st.stage_byte = `ERASED_BYTE;
      if (!st.out_status)
        next_st.col = st.col + COL_W'(1);
    end

    // ready only when no LUN is busy
    next_st.hout.rb = ~|lun_busy;
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      st <= '0;
      st.hout.rb <= 1'b1;
    end
    else
      st <= next_st;
  end

  assign o_host          = st.hout;
  assign o_otp_mode      = st.otp_mode;
  assign o_otp_protected = st.prot;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);

  sequence protect_start_s;
    protect_go && !st.prot;
  endsequence
  sequence held_busy_s;
    (!o_host.rb)[*8];
  endsequence

  rb_all_idle_a: assert property ($past(|lun_busy) |-> !o_host.rb)
    else $error("ready/busy high while a LUN is busy");
  rb_ready_a: assert property (!(|lun_busy) && !$past(|lun_busy) |-> o_host.rb)
    else $error("ready/busy low with all LUNs idle");
  protect_busy_a: assert property (protect_start_s |-> ##2 held_busy_s)
    else $error("protect did not hold busy");
  refused_status_a: assert property (i_host.data_re && st.out_status && st.refused[st.sel_lun]
      && !lun_busy[st.sel_lun] |=> st.stage_byte == `STATUS_REFUSED)
    else $error("refused status is not 60h");
  reprotect_busy_a: assert property (protect_go && st.prot |=> lun_busy[st.sel_lun]
      && st.refused[st.sel_lun])
    else $error("second protect not refused");
  protect_sticky_a: assert property ($past(st.prot) |-> st.prot)
    else $error("protection was removed");
  no_write_prot_a: assert property (mem_we |-> !st.prot)
    else $error("write into protected area");
  read_busy_a: assert property (otp_read_go |=> lun_busy[st.sel_lun] ##1 !o_host.rb)
    else $error("one-time read did not go busy");
  read_unprot_a: assert property (otp_read_go && st.prot |=> lun_busy[st.sel_lun])
    else $error("read refused after protection");
  read_mode_a: assert property (i_host.cmd_we && i_host.io == `CMD_READ_MODE
      |=> !st.out_status)
    else $error("read mode kept status output");
  otp_enter_a: assert property (feat_done && st.feat_addr == `FEAT_OTP_ADDR
      && st.feat_p1 == `OTP_ENTER && next_st.feat_zero |=> st.otp_mode)
    else $error("one-time mode not entered");

endmodule

// *** src/nand_otp_consts.svh ***
// Constants for the one-time area and LUN sequencer
`ifndef NAND_OTP_CONSTS_SVH
`define NAND_OTP_CONSTS_SVH

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS          25
`define ARRAY_PROGRAM_TIME_NS  200000
`define PAGE_READ_TIME_NS      25000
// Figure not published; plain default
`define OTP_BUSY_TIME_NS       30000

// ****************************************
// Command codes
// ****************************************
`define CMD_READ_MODE    8'h00
`define CMD_READ_GO      8'h30
`define CMD_PROG         8'h80
`define CMD_PROG_GO      8'h10
`define CMD_STATUS       8'h70
`define CMD_STATUS_LUN   8'h78
`define CMD_COL_CHG      8'h05
`define CMD_COL_GO       8'hE0
`define CMD_CACHE_SEL    8'h06
`define CMD_SET_FEAT     8'hEF
`define CMD_RESET        8'hFF
`define CMD_SYNC_RESET   8'hFC

// ****************************************
// Feature, page and status values
// ****************************************
`define FEAT_OTP_ADDR    8'h90
`define OTP_ENTER        8'h01
`define OTP_PAGE_FIRST   8'h02
`define OTP_PAGE_LAST    8'h1F
`define PROTECT_ADDR     40'h00_00_01_00_00
`define STATUS_REFUSED   8'h60
`define SR_ARRAY_READY_FLAG          5
`define SR_RDY           6
`define BAD_BLOCK_BYTE   13'h1000
`define BAD_BLOCK_MARK   8'h00
`define ERASED_BYTE      8'hFF

`endif

// *** src/nand_otp_pkg.sv ***
// Types shared by the one-time area and LUN sequencer
package nand_otp_pkg;

  localparam int LUN_N = 2;
  localparam int COL_W = 13;
  localparam int CYC_W = 20;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_READ = 3'b001,
    OP_PROG = 3'b010,
    OP_FEAT = 3'b011,
    OP_SEL  = 3'b100,
    OP_COL  = 3'b101
  } op_t;

  typedef struct packed {
    logic       cmd_we;
    logic       addr_we;
    logic       data_we;
    logic       data_re;
    logic [7:0] io;
  } host_in_t;

  typedef struct packed {
    logic [7:0] dout;
    logic       dout_valid;
    logic       rb;
  } host_out_t;

  typedef struct packed {
    logic             busy;
    logic [CYC_W-1:0] cnt;
  } timer_state_t;

  typedef struct packed {
    op_t              op;
    logic [2:0]       acnt;
    logic [4:0][7:0]  addr;
    logic [2:0]       pcnt;
    logic [7:0]       feat_addr;
    logic [7:0]       feat_p1;
    logic             feat_zero;
    logic             otp_mode;
    logic             prot;
    logic [LUN_N-1:0] pend_prot;
    logic [LUN_N-1:0] refused;
    logic [LUN_N-1:0] busy_q;
    logic             out_status;
    logic             sel_lun;
    logic [COL_W-1:0] col;
    logic [4:0]       rd_page;
    logic             rd_otp;
    logic             rd_bad;
    logic             rd_stage;
    logic             stage_mem;
    logic [7:0]       stage_byte;
    host_out_t        hout;
  } seq_state_t;

endpackage

// *** src/lun_timer.sv ***
// Busy timer for one LUN
`timescale 1ns/100ps
module lun_timer
  import nand_otp_pkg::*;
(
  input  wire logic             i_sys_clk,
  input  wire logic             i_nrst,
  input  wire logic             i_start,
  input  wire logic [CYC_W-1:0] i_cycles,
  output logic                  o_busy
);

  timer_state_t st;
  timer_state_t next_st;

  always_comb
  begin
    next_st = st;
    if (i_start)
    begin
      next_st.busy = 1'b1;
      next_st.cnt  = i_cycles;
    end
    else if (st.busy)
    begin
      // Busy for exactly i_cycles edges
      if (st.cnt <= CYC_W'(1))
        next_st.busy = 1'b0;
      next_st.cnt = st.cnt - CYC_W'(1);
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      st <= '0;
    else
      st <= next_st;
  end

  assign o_busy = st.busy;

endmodule

// *** src/otp_page_mem.sv ***
// Byte memory holding the one-time pages
`timescale 1ns/100ps
module otp_page_mem #(
  parameter int AW = 18
) (
  input  wire logic          i_sys_clk,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [7:0]    i_wdata,
  input  wire logic [AW-1:0] i_raddr,
  output logic [7:0]         o_rdata
);

  logic [7:0] mem [0:(1<<AW)-1];

  // No reset: array contents are not control state
  always_ff @(posedge i_sys_clk)
  begin
    if (i_we)
      mem[i_waddr] <= i_wdata;
    o_rdata <= mem[i_raddr];
  end

endmodule

// *** bench/nand_host_model.sv ***
// Host controller model: strobes, byte reads and ready polling
`timescale 1ns/100ps
module nand_host_model
  import nand_otp_pkg::*;
(
  input  wire logic i_sys_clk,
  input  host_out_t i_dev,
  output host_in_t  o_host
);
  int unsigned low_cnt = 0;

  initial o_host = '0;

  // ****************************************
  // Busy span counter
  // ****************************************
  always @(posedge i_sys_clk)
  begin
    if (i_dev.rb === 1'b0)
      low_cnt <= low_cnt + 1;
  end

  // ****************************************
  // Bus cycles
  // ****************************************
  // Whole struct written once per step, so back-to-back strobes never glitch
  task automatic strobe(input int kind, input logic [7:0] val);
    host_in_t h;
    h = '0;
    h.io = val;
    h.cmd_we = (kind == 0);
    h.addr_we = (kind == 1);
    h.data_we = (kind == 2);
    h.data_re = (kind == 3);
    o_host = h;
    @(posedge i_sys_clk);
    #2;
  endtask

  task automatic idle();
    o_host = '0;
    @(posedge i_sys_clk);
    #2;
  endtask

  task automatic addr5(input logic [39:0] a);
    for (int i = 4; i >= 0; i--)
      strobe(1, a[i*8 +: 8]);
  endtask

  task automatic seq(input logic [7:0] c, input logic [39:0] a, input logic [7:0] g);
    strobe(0, c);
    addr5(a);
    strobe(0, g);
  endtask

  // Unknown when no valid pulse, so a missing byte never matches
  task automatic read_byte(output logic [7:0] v);
    strobe(3, 8'h00);
    o_host = '0;
    @(posedge i_sys_clk);
    #2;
    v = (i_dev.dout_valid === 1'b1) ? i_dev.dout : 8'hXX;
  endtask

  task automatic status(output logic [7:0] v);
    strobe(0, 8'h70);
    read_byte(v);
  endtask

  task automatic status_lun(input logic [23:0] rows, output logic [7:0] v);
    strobe(0, 8'h78);
    strobe(1, rows[23:16]);
    strobe(1, rows[15:8]);
    strobe(1, rows[7:0]);
    read_byte(v);
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    repeat (3) @(posedge i_sys_clk);
    #2;
    while (i_dev.rb !== 1'b1 && n < 4000)
    begin
      @(posedge i_sys_clk);
      #2;
      n++;
    end
  endtask
endmodule

// *** bench/tb.sv ***
// Self-checking bench for the one-time area and LUN sequencer
`timescale 1ns/100ps
`include "nand_otp_consts.svh"
module tb
  import nand_otp_pkg::*;
;
  localparam int unsigned PROG_CYC = 20;
  localparam int unsigned OBSY_CYC = 12;
  localparam int unsigned READ_CYC = 10;
  localparam logic [15:0] BAD_BLK  = 16'h0005;

  logic        i_sys_clk;
  logic        i_nrst;
  host_in_t    hin;
  host_out_t   hout;
  logic        otp_mode;
  logic        otp_prot;
  int          fails;
  int          num_checks;
  logic [7:0]  b;
  logic [7:0]  wr [$];
  logic [7:0]  inv [$];
  logic [7:0]  zq [$];
  logic [6:0]  pg;
  logic [12:0] col;
  logic [15:0] blk;

  nand_otp_seq #(
    .ARRAY_PROGRAM_CYC (PROG_CYC),
    .OTP_BUSY_CYC      (OBSY_CYC),
    .PAGE_READ_CYC     (READ_CYC),
    .FACTORY_BAD_BLOCK (BAD_BLK),
    .LUN_BIT           (0)
  ) uut (
    .i_sys_clk       (i_sys_clk),
    .i_nrst          (i_nrst),
    .i_host          (hin),
    .o_host          (hout),
    .o_otp_mode      (otp_mode),
    .o_otp_protected (otp_prot)
  );

  nand_host_model host (
    .i_sys_clk (i_sys_clk),
    .i_dev     (hout),
    .o_host    (hin)
  );

  // ****************************************
  // Expectations and comparisons
  // ****************************************
  // one address per operation, shared LUN and page bits
  function automatic logic [39:0] mk_addr(input logic [15:0] bk, input logic [6:0] p,
                                          input logic [12:0] c);
    return {c[7:0], 3'h0, c[12:8], bk[0], p, bk[8:1], 4'h0, bk[12:9]};
  endfunction

  function automatic logic [7:0] stat_exp(input logic busy, input logic refused);
    return {~refused, ~busy, ~busy, 5'h00};
  endfunction

  function automatic logic [7:0] bb_exp(input logic [15:0] bk, input logic [12:0] c);
    return (bk == BAD_BLK && c == 13'h1000) ? 8'h00 : 8'hFF;
  endfunction

  task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_bit(input string name, input logic exp, input logic got);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic chk_cnt(input string name, input int unsigned exp, input int unsigned got);
    num_checks++;
    if (got != exp)
    begin
      fails++;
      $display("MISMATCH %s expected %0d seen %0d", name, exp, got);
    end
  endtask

  task automatic complete_run();
    if (fails == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ****************************************
  // Operations
  // ****************************************
  task automatic set_otp(input logic [7:0] p1);
    host.strobe(0, 8'hEF);
    host.strobe(1, 8'h90);
    host.strobe(2, p1);
    repeat (3) host.strobe(2, 8'h00);
    host.idle();
  endtask

  task automatic prog(input logic [39:0] a, input logic [7:0] v [$], input int unsigned cyc,
                      input logic [7:0] st);
    host.low_cnt = 0;
    host.strobe(0, 8'h80);
    host.addr5(a);
    foreach (v[i]) host.strobe(2, v[i]);
    host.strobe(0, 8'h10);
    host.idle();
    host.wait_ready();
    chk_cnt("busy cycles", cyc, host.low_cnt);
    host.status(b);
    chk_byte("status", st, b);
  endtask

  task automatic read_page(input logic [39:0] a, input logic [7:0] v [$]);
    logic [12:0] c2;
    c2 = {a[28:24], a[39:32]} + 13'h0002;
    host.low_cnt = 0;
    host.seq(8'h00, a, 8'h30);
    host.status(b);
    chk_byte("busy status", stat_exp(1'b1, 1'b0), b);
    host.wait_ready();
    chk_cnt("read busy cycles", READ_CYC, host.low_cnt);
    host.status(b);
    chk_byte("ready status", stat_exp(1'b0, 1'b0), b);
    host.strobe(0, 8'h00);
    foreach (v[i])
    begin
      host.read_byte(b);
      chk_byte("page byte", v[i], b);
    end
    host.strobe(0, 8'h05);
    host.strobe(1, c2[7:0]);
    host.strobe(1, {3'h0, c2[12:8]});
    host.strobe(0, 8'hE0);
    host.read_byte(b);
    chk_byte("moved column byte", v[2], b);
  endtask

  // ****************************************
  // Clock, watchdog and sequence
  // ****************************************
  initial
  begin
    i_sys_clk = 1'b0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end

  // Whole run is a few hundred cycles; this leaves ample margin
  initial
  begin
    #1000000;
    fails++;
    complete_run();
  end

  initial
  begin
    fails = 0;
    num_checks = 0;
    i_nrst = 1'b0;
    zq = {8'h00};
    void'($urandom(32'h3c5b26e5));
    repeat (8) @(posedge i_sys_clk);
    #2;
    i_nrst = 1'b1;
    chk_bit("ready after reset", 1'b1, hout.rb);
    chk_bit("otp mode", 1'b0, otp_mode);
    chk_bit("protected", 1'b0, otp_prot);
    for (int i = 0; i < 6; i++)
    begin
      blk = (i < 2) ? BAD_BLK : 16'($urandom_range(0, 15));
      col = (i == 1) ? 13'h0FFF : 13'($urandom_range(4095, 4097));
      col = (i == 0) ? 13'h1000 : col;
      host.seq(8'h00, mk_addr(blk, 7'h00, col), 8'h30);
      host.idle();
      host.wait_ready();
      host.read_byte(b);
      chk_byte("mark byte", bb_exp(blk, col), b);
    end
    set_otp(8'h01);
    chk_bit("otp mode", 1'b1, otp_mode);
    pg = 7'(2 + $urandom_range(0, 29));
    col = 13'($urandom_range(0, 3));
    for (int i = 0; i < 4; i++)
    begin
      wr.push_back(8'($urandom));
      inv.push_back(~wr[i]);
    end
    prog(mk_addr(16'h0000, pg, col), wr, PROG_CYC, stat_exp(1'b0, 1'b0));
    read_page(mk_addr(16'h0000, pg, col), wr);
    prog(`PROTECT_ADDR, zq, PROG_CYC, stat_exp(1'b0, 1'b0));
    chk_bit("protected", 1'b1, otp_prot);
    prog(`PROTECT_ADDR, zq, OBSY_CYC, `STATUS_REFUSED);
    prog(mk_addr(16'h0000, pg, col), inv, OBSY_CYC, `STATUS_REFUSED);
    read_page(mk_addr(16'h0000, pg, col), wr);
    set_otp(8'h00);
    chk_bit("otp mode", 1'b0, otp_mode);
    host.low_cnt = 0;
    host.seq(8'h00, mk_addr(16'h0000, 7'h00, 13'h0000), 8'h30);
    host.seq(8'h00, mk_addr(16'h0200, 7'h00, 13'h0000), 8'h30);
    host.idle();
    host.wait_ready();
    chk_cnt("joint busy cycles", 7 + READ_CYC, host.low_cnt);
    for (int l = 0; l < 2; l++)
    begin
      host.status_lun(24'(mk_addr(16'(l) << 9, 7'h00, 13'h0000)), b);
      chk_byte("lun status", stat_exp(1'b0, 1'b0), b);
    end
    complete_run();
  end
endmodule
